//--- uocs_pkg.sv
/*
  Package for the dual-role port control and status block: register offsets,
  field positions, reset values and timing constants.
  Assumes a 100 MHz system clock and a 32-bit APB register bus.
*/
package uocs_pkg;

  // register byte offsets on the APB word map
  localparam logic [7:0] OFS_LINE_SESSION_STATUS   = 8'h00;
  localparam logic [7:0] OFS_PULL_AND_VBUS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_POWER_SUSPEND_CONTROL = 8'h08;
  localparam logic [7:0] OFS_LAST_TRANSFER_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_MODULE_CONTROL        = 8'h10;

  // line/session status fields
  localparam int BIT_PLUG_TYPE     = 7;
  localparam int BIT_LINE_STABLE   = 5;
  localparam int BIT_SESSION_VALID = 3;
  localparam int BIT_SESSION_END   = 2;
  localparam int BIT_VBUS_VALID    = 0;

  // pull and vbus control fields
  localparam int BIT_DP_PULLUP   = 7;
  localparam int BIT_DM_PULLUP   = 6;
  localparam int BIT_DP_PULLDOWN = 5;
  localparam int BIT_DM_PULLDOWN = 4;
  localparam int BIT_VBUS_POWER  = 3;
  localparam int BIT_DUAL_ROLE   = 2;
  localparam int BIT_VBUS_CHARGE = 1;
  localparam int BIT_VBUS_DISCH  = 0;

  // power/suspend control fields
  localparam int BIT_ACT_PENDING = 7;
  localparam int BIT_SLEEP_GUARD = 4;
  localparam int BIT_SUSPEND     = 1;
  localparam int BIT_MODULE_PWR  = 0;

  // last transfer status fields
  localparam int BIT_EP_LSB  = 4;
  localparam int BIT_DIR     = 3;
  localparam int BIT_PPBANK  = 2;

  // module control fields (host role, attach)
  localparam int BIT_HOST_ROLE = 3;
  localparam int BIT_ATTACH    = 0;

  // implemented-bit masks
  localparam logic [7:0] MASK_PULL_VBUS = 8'hFF;
  localparam logic [7:0] MASK_PWR_SUSP  = 8'h13;
  localparam logic [7:0] MASK_MOD_CTRL  = 8'h09;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // line state must hold for this long before it counts as stable
  localparam int STABLE_TIME_US  = 1000;
  localparam int CLK_MHZ         = 100;
  localparam int STABLE_CYCLES   = STABLE_TIME_US * CLK_MHZ;

endpackage

//--- uocs_top.sv
/*
  Dual-role port control and status block, APB slave.
  Holds the line/session status word, the pull and vbus control word, the
  power and suspend word, the last-transfer status word and a small module
  control word carrying the host role and attach bits that steer the
  hardware choice of resistors.

  Assumes synchronous inputs from comparators, line receivers and the serial
  engine; resistor and vbus outputs drive analog switches directly.
  Assumes the serial engine raises xfer_done for one cycle per completed
  transfer, with endpoint, direction and bank valid in that same cycle.
  Assumes resume_wake is a one-cycle pulse from the wake detector.

  Limitations: every register is one byte in the low byte of its word; the
  upper bytes read zero. Unmapped words answer with pslverr. The stability
  timer counts system clocks, so STABLE_CYCLES must match the clock rate.
  Read data is loaded in the setup cycle, so the register bus never waits.
*/
// Register access over APB and the register addresses were left to the implementer.
// Overview of operation
// - plug-type bit reads 1 with nothing or B cable, 0 with A plug.
// - line-stable bit is 1 only after line state unchanged for 1 ms.
// - session-valid bit follows the session-valid comparator.
// - session-end bit follows the session-end comparator.
// - vbus-valid bit follows the vbus-valid comparator.
// - upper byte and unimplemented bits read zero, ignore writes.
// - D+ and D- pull-up bits each connect their pull-up resistor.
// - D+ and D- pull-down bits each connect their pull-down resistor.
// - vbus power bit turns on the vbus supply.
// - dual-role enable selects software pulls; otherwise host/attach bits choose.
// - charge select picks 3.3V when 1, 5V when 0.
// - discharge bit switches in the resistive vbus discharge path.
// - hardware sets activity-pending on bus activity; meaningful while guard set.
// - suspend gates usb clock, lowers transceiver power; hardware may clear.
// - four-bit field holds endpoint number of last transfer.
// - direction bit reads 1 for transmit, 0 for receive.
// - bank bit reads 1 for odd bank, 0 for even.
// - last-transfer fields update with the transfer-done flag.
`timescale 1ns/1ps

module uocs_top #(
  parameter int STABLE_CYCLES = uocs_pkg::STABLE_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // cable-side levels, already synchronous
  input  wire logic        plug_id_in,
  input  wire logic        line_se0,
  input  wire logic        line_jstate,
  input  wire logic        cmp_session_valid,
  input  wire logic        cmp_session_end,
  input  wire logic        cmp_vbus_valid,
  // activity, wake and completion events
  input  wire logic        bus_activity,
  input  wire logic        resume_wake,
  input  wire logic        xfer_done,
  input  wire logic [3:0]  xfer_endpoint,
  input  wire logic        xfer_tx,
  input  wire logic        xfer_odd,
  // analog switch and power controls
  output logic             dplus_pullup_on,
  output logic             dminus_pullup_on,
  output logic             dplus_pulldown_on,
  output logic             dminus_pulldown_on,
  output logic             vbus_supply_on,
  output logic             vbus_charge_3v3,
  output logic             vbus_discharge_on,
  output logic             module_power_on,
  output logic             usb_clock_gate,
  output logic             xcvr_low_power,
  output logic             transfer_done_flag
);

  // software-owned control state
  logic [7:0]  pull_ctrl_q;
  logic [7:0]  mod_ctrl_q;
  logic        sleep_guard_q;
  logic        suspend_enable_q;
  logic        module_power_enable_q;

  // hardware-owned status state
  logic        activity_pending_flag_q;
  logic        act_set;
  logic [7:0]  status_q;
  logic [7:0]  status_d;
  logic [7:0]  last_xfer_q;
  logic [7:0]  last_xfer_d;
  logic        done_q;

  // line stability timer
  logic [1:0]  line_prev_q;
  logic [1:0]  line_now;
  logic        line_changed;
  logic        stable_reached;
  logic [31:0] stable_cnt_q;
  logic        line_stable_flag_q;

  // bus decode and read path
  logic        access;
  logic        wr_en;
  logic        rd_setup;
  logic        addr_ok;
  logic        sel_pull;
  logic        sel_power;
  logic        sel_mod;
  logic        wr_pull;
  logic        wr_power;
  logic        wr_mod;
  logic [7:0]  pwr_byte;
  logic [7:0]  rd_byte;
  logic [31:0] rd_word;
  logic [7:0]  wbyte;

  // hardware resistor choice when dual-role is off
  logic        hw_dp_pullup;
  logic        hw_dp_pulldown;
  logic        hw_dm_pulldown;

  // access phase and write/read strobes
  assign access   = psel && penable;
  assign wbyte    = pwdata[7:0];
  assign wr_en    = access && pwrite;
  assign rd_setup = psel && !penable && !pwrite; // prdata loads a cycle early
  assign pready   = 1'b1; // zero wait state: nothing here needs time
  assign pslverr  = access && !addr_ok;

  // per-register selects; writes to read-only words fall through
  assign sel_pull  = paddr == uocs_pkg::OFS_PULL_AND_VBUS_CONTROL;
  assign sel_power = paddr == uocs_pkg::OFS_POWER_SUSPEND_CONTROL;
  assign sel_mod   = paddr == uocs_pkg::OFS_MODULE_CONTROL;
  assign wr_pull   = wr_en && sel_pull;
  assign wr_power  = wr_en && sel_power;
  assign wr_mod    = wr_en && sel_mod;

  // address decode
  always_comb begin
    addr_ok = 1'b1;
    case (paddr)
      uocs_pkg::OFS_LINE_SESSION_STATUS,
      uocs_pkg::OFS_PULL_AND_VBUS_CONTROL,
      uocs_pkg::OFS_POWER_SUSPEND_CONTROL,
      uocs_pkg::OFS_LAST_TRANSFER_STATUS,
      uocs_pkg::OFS_MODULE_CONTROL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // pull and vbus control register, all bits writable
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pull_ctrl_q <= uocs_pkg::RESET_BYTE;
    end else if (wr_pull) begin
      pull_ctrl_q <= wbyte & uocs_pkg::MASK_PULL_VBUS;
    end
  end

  // host role and attach bits
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_ctrl_q <= uocs_pkg::RESET_BYTE;
    end else if (wr_mod) begin
      mod_ctrl_q <= wbyte & uocs_pkg::MASK_MOD_CTRL;
    end
  end

  // sleep guard, software owned; warns of an imminent suspend
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_guard_q <= 1'b0;
    end else if (wr_power) begin
      sleep_guard_q <= wbyte[uocs_pkg::BIT_SLEEP_GUARD];
    end
  end

  // module power enable; software must drop the roles before clearing it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      module_power_enable_q <= 1'b0;
    end else if (wr_power) begin
      module_power_enable_q <= wbyte[uocs_pkg::BIT_MODULE_PWR];
    end
  end

  // suspend: hardware clears on resume wake; the clear wins only over a
  // write in the same cycle, so a wake is never lost
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      suspend_enable_q <= 1'b0;
    end else if (resume_wake) begin
      suspend_enable_q <= 1'b0;
    end else if (wr_power) begin
      suspend_enable_q <= wbyte[uocs_pkg::BIT_SUSPEND];
    end
  end

  // activity only counts while software has announced a suspend
  assign act_set = bus_activity && sleep_guard_q;

  // activity pending: set by activity while guarded, software writes 0 to clear
  // set wins over a clear arriving in the same cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      activity_pending_flag_q <= 1'b0;
    end else if (act_set) begin
      activity_pending_flag_q <= 1'b1;
    end else if (!sleep_guard_q) begin
      activity_pending_flag_q <= 1'b0; // no meaning without guard
    end else if (wr_power) begin
      activity_pending_flag_q <= wbyte[uocs_pkg::BIT_ACT_PENDING];
    end
  end

  // line-state compare; se0 and j together form the state that must hold
  assign line_now       = {line_se0, line_jstate};
  assign line_changed   = line_prev_q != line_now;
  assign stable_reached = stable_cnt_q >= 32'(STABLE_CYCLES - 1);

  // previous line state, one cycle behind the pins
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_prev_q <= 2'h0;
    end else begin
      line_prev_q <= line_now;
    end
  end

  // stability counter; stops at the end so it never wraps back to unstable
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stable_cnt_q <= 32'h0;
    end else if (line_changed) begin
      stable_cnt_q <= 32'h0;
    end else if (!stable_reached) begin
      stable_cnt_q <= stable_cnt_q + 32'h1;
    end
  end

  // stable flag drops the cycle after any change
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_stable_flag_q <= 1'b0;
    end else if (line_changed) begin
      line_stable_flag_q <= 1'b0;
    end else if (stable_reached) begin
      line_stable_flag_q <= 1'b1;
    end
  end

  // comparator and plug levels gathered into the status byte
  always_comb begin
    status_d                              = 8'h00;
    status_d[uocs_pkg::BIT_PLUG_TYPE]     = plug_id_in;
    status_d[uocs_pkg::BIT_LINE_STABLE]   = line_stable_flag_q;
    status_d[uocs_pkg::BIT_SESSION_VALID] = cmp_session_valid;
    status_d[uocs_pkg::BIT_SESSION_END]   = cmp_session_end;
    status_d[uocs_pkg::BIT_VBUS_VALID]    = cmp_vbus_valid;
  end

  // status byte registered once, so a read never sees a half-settled level
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= uocs_pkg::RESET_BYTE;
    end else begin
      status_q <= status_d;
    end
  end

  // completion fields packed into the status byte layout
  assign last_xfer_d = {xfer_endpoint, xfer_tx, xfer_odd, 2'b00};

  // last transfer capture on completion
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_xfer_q <= uocs_pkg::RESET_BYTE;
    end else if (xfer_done) begin
      last_xfer_q <= last_xfer_d;
    end
  end

  // transfer-done flag raised in the same edge as the capture
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= xfer_done;
    end
  end
  assign transfer_done_flag = done_q;

  // power word: only pending, guard, suspend and power bits exist
  always_comb begin
    pwr_byte                            = 8'h00;
    pwr_byte[uocs_pkg::BIT_ACT_PENDING] = activity_pending_flag_q;
    pwr_byte[uocs_pkg::BIT_SLEEP_GUARD] = sleep_guard_q;
    pwr_byte[uocs_pkg::BIT_SUSPEND]     = suspend_enable_q;
    pwr_byte[uocs_pkg::BIT_MODULE_PWR]  = module_power_enable_q;
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    case (paddr)
      uocs_pkg::OFS_LINE_SESSION_STATUS:   rd_byte = status_q;
      uocs_pkg::OFS_PULL_AND_VBUS_CONTROL: rd_byte = pull_ctrl_q;
      uocs_pkg::OFS_POWER_SUSPEND_CONTROL: rd_byte = pwr_byte;
      uocs_pkg::OFS_LAST_TRANSFER_STATUS:  rd_byte = last_xfer_q;
      uocs_pkg::OFS_MODULE_CONTROL:        rd_byte = mod_ctrl_q;
      default:                             rd_byte = 8'h00;
    endcase
  end

  // upper three bytes are never implemented
  assign rd_word = {24'h0, rd_byte};

  // read data register; upper 24 bits always zero
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

  // hardware choice: a host wants both pull-downs, an attached device D+ pull-up
  assign hw_dp_pullup   = mod_ctrl_q[uocs_pkg::BIT_ATTACH] && !mod_ctrl_q[uocs_pkg::BIT_HOST_ROLE];
  assign hw_dp_pulldown = mod_ctrl_q[uocs_pkg::BIT_HOST_ROLE];
  assign hw_dm_pulldown = mod_ctrl_q[uocs_pkg::BIT_HOST_ROLE];

  // resistor selection: software bits when dual-role enabled, else hardware
  always_comb begin
    if (pull_ctrl_q[uocs_pkg::BIT_DUAL_ROLE]) begin
      dplus_pullup_on    = pull_ctrl_q[uocs_pkg::BIT_DP_PULLUP];
      dminus_pullup_on   = pull_ctrl_q[uocs_pkg::BIT_DM_PULLUP];
      dplus_pulldown_on  = pull_ctrl_q[uocs_pkg::BIT_DP_PULLDOWN];
      dminus_pulldown_on = pull_ctrl_q[uocs_pkg::BIT_DM_PULLDOWN];
    end else begin
      dplus_pullup_on    = hw_dp_pullup;
      dminus_pullup_on   = 1'b0;           // hardware never picks the D- pull-up
      dplus_pulldown_on  = hw_dp_pulldown;
      dminus_pulldown_on = hw_dm_pulldown;
    end
  end

  // vbus and power outputs
  assign vbus_supply_on    = pull_ctrl_q[uocs_pkg::BIT_VBUS_POWER];
  assign vbus_charge_3v3   = pull_ctrl_q[uocs_pkg::BIT_VBUS_CHARGE];
  assign vbus_discharge_on = pull_ctrl_q[uocs_pkg::BIT_VBUS_DISCH];

  // power and suspend side effects
  assign module_power_on   = module_power_enable_q;
  assign usb_clock_gate    = suspend_enable_q;
  assign xcvr_low_power    = suspend_enable_q;

endmodule

//--- uocs_assertions.sv
/* Checker for the dual-role port control block, on its top-level ports.
   Assumes the APB write lands at the access edge and its outputs follow a cycle later. */
`timescale 1ns/1ps
module uocs_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        resume_wake,
  input wire logic        xfer_done,
  input wire logic        transfer_done_flag,
  input wire logic        dplus_pullup_on,
  input wire logic        dminus_pullup_on,
  input wire logic        dplus_pulldown_on,
  input wire logic        dminus_pulldown_on,
  input wire logic        vbus_supply_on,
  input wire logic        vbus_charge_3v3,
  input wire logic        usb_clock_gate,
  input wire logic        xcvr_low_power
);
  logic wr04;
  logic wr08;
  // write strobes of the pull/vbus and power words
  assign wr04 = psel && penable && pwrite && paddr == 8'h04;
  assign wr08 = psel && penable && pwrite && paddr == 8'h08;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_done_flag: assert property (xfer_done |=> transfer_done_flag)
    else $error("done flag missing after completion");
  a_vbus_power: assert property (wr04 |=> vbus_supply_on == $past(pwdata[3]))
    else $error("vbus supply does not follow its bit");
  a_charge_level: assert property (wr04 |=> vbus_charge_3v3 == $past(pwdata[1]))
    else $error("charge level does not follow its bit");
  a_pullup_soft: assert property (wr04 && pwdata[2] |=> {dplus_pullup_on, dminus_pullup_on} == $past(pwdata[7:6]))
    else $error("pull-ups do not follow software bits");
  a_pulldown_soft: assert property (wr04 && pwdata[2] |=> {dplus_pulldown_on, dminus_pulldown_on} == $past(pwdata[5:4]))
    else $error("pull-downs do not follow software bits");
  a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("no error on unmapped word");
  a_suspend_set: assert property (wr08 && !resume_wake |=> usb_clock_gate == $past(pwdata[1]))
    else $error("clock gate does not follow suspend bit");
  a_suspend_pair: assert property (usb_clock_gate == xcvr_low_power)
    else $error("clock gate and low power disagree");
  // main scenarios reached
  cover property (wr04 && pwdata[2]);
  cover property (xfer_done);
  cover property (resume_wake && usb_clock_gate);
endmodule
bind uocs_top uocs_assertions i_chk (.*);

//--- uocs_cable_model.sv
/* Cable-side model: plug id, line receivers and vbus comparators.
   Assumes the bench sets plug kind, vbus level code and line state. */
`timescale 1ns/1ps
module uocs_cable_model (
  input  wire logic       a_plug,
  input  wire logic [1:0] vbus_lvl,
  input  wire logic [1:0] line_st,
  output logic            plug_id_in,
  output logic            line_se0,
  output logic            line_jstate,
  output logic            cmp_session_valid,
  output logic            cmp_session_end,
  output logic            cmp_vbus_valid
);
  // id pin pulled high unless an A plug grounds it
  assign plug_id_in = !a_plug;
  assign {line_se0, line_jstate} = line_st;
  // session-valid and vbus-valid thresholds are nested; session-end is set only at level code 0
  assign cmp_session_end = vbus_lvl == 2'h0;
  assign cmp_session_valid = vbus_lvl >= 2'h2;
  assign cmp_vbus_valid = vbus_lvl == 2'h3;
endmodule

//--- uocs_tb_top.sv
/* Self-checking bench for the dual-role port control block with the cable model.
   Stand-alone; stability count shortened to 20 cycles. */
`timescale 1ns/1ps
`define CHK(nm, x, g) begin n_compared++; if ((g) !== (x)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, x, g); end end
module uocs_tb_top;
  logic        sys_clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0, pslverr, pready, e;
  logic        a_plug = '0, bus_activity = '0, resume_wake = '0, xfer_done = '0, xfer_tx = '0, xfer_odd = '0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic [3:0]  xfer_endpoint = '0, pulls;
  logic [1:0]  vbus_lvl = '0, line_st = 2'h1;
  logic        plug_id_in, line_se0, line_jstate, cmp_session_valid, cmp_session_end, cmp_vbus_valid;
  logic        dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on, dminus_pulldown_on, vbus_supply_on;
  logic        vbus_charge_3v3, vbus_discharge_on, module_power_on, usb_clock_gate, xcvr_low_power;
  logic        transfer_done_flag;
  logic [7:0]  ct [4] = '{8'hFF, 8'hA6, 8'h56, 8'h04};
  logic [7:0]  xt [3] = '{8'hFC, 8'h00, 8'h98};
  int          err_total = 0, n_compared = 0, cyc = 0;
  uocs_top #(.STABLE_CYCLES(20)) i_dut (.*);
  uocs_cable_model i_cable (.*);
  assign pulls = {dplus_pullup_on, dminus_pullup_on, dplus_pulldown_on, dminus_pulldown_on};
  always #5 sys_clk = ~sys_clk;
  // watchdog well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= '1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    {e, r} = {pslverr, prdata};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb('0, a, '0);
    `CHK("register", x, r)
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= '0;
    for (int i = 1; i < 5; i++) rdc(8'(i * 4), 32'h0); // cleared words
    repeat (40) @(posedge sys_clk);
    // every plug kind and vbus level with a quiet line
    for (int i = 0; i < 8; i++) begin
      {a_plug, vbus_lvl} <= 3'(i);
      repeat (3) @(posedge sys_clk);
      rdc(8'h00, {24'h0, !i[2], 2'b01, 1'b0, i[1:0] >= 2'h2, i[1:0] == 2'h0, 1'b0, i[1:0] == 2'h3});
    end
    // a line change restarts the stability count
    line_st <= 2'h2;
    repeat (10) @(posedge sys_clk);
    rdc(8'h00, 32'h09); // still unstable
    repeat (30) @(posedge sys_clk);
    rdc(8'h00, 32'h29); // stable again
    // host role first; with dual-role set, pulls and vbus follow their bits in that role
    apb('1, 8'h10, 32'h08); // host mode
    foreach (ct[i]) begin
      apb('1, 8'h04, {24'hFFFFFF, ct[i]});
      rdc(8'h04, {24'h0, ct[i]}); // upper bits dropped
      `CHK("pulls", ct[i][7:4], pulls) // resistor bits
      `CHK("vbus", {ct[i][3], ct[i][1:0]}, {vbus_supply_on, vbus_charge_3v3, vbus_discharge_on})
    end
    // software pulls off: the host role picks both pull-downs
    apb('1, 8'h04, 32'h0);
    @(posedge sys_clk);
    `CHK("hw pulls", 4'h3, pulls) // hardware choice
    apb('1, 8'h10, 32'h01); // attach without host role
    @(posedge sys_clk);
    `CHK("attach pulls", 4'h8, pulls) // hardware D+ pull-up
    apb('1, 8'h10, 32'h0); // roles off before power
    apb('1, 8'h08, 32'h13); // guard with suspend
    rdc(8'h08, 32'h13);
    `CHK("suspend", 3'h7, {usb_clock_gate, xcvr_low_power, module_power_on})
    resume_wake <= '1;
    @(posedge sys_clk);
    resume_wake <= '0;
    bus_activity <= '1;
    @(posedge sys_clk);
    bus_activity <= '0;
    rdc(8'h08, 32'h91); // wake and activity
    apb('1, 8'h08, 32'h81);
    rdc(8'h08, 32'h01); // no guard, no pending
    apb('1, 8'h08, 32'h0); // power off last
    // last-transfer fields, one completion each
    foreach (xt[i]) begin
      xfer_done <= '1;
      {xfer_endpoint, xfer_tx, xfer_odd} <= xt[i][7:2];
      @(posedge sys_clk);
      xfer_done <= '0;
      #1;
      `CHK("done flag", 1'b1, transfer_done_flag)
      rdc(8'h0C, {24'h0, xt[i]});
    end
    rdc(8'h14, 32'h0); // unmapped reads zero
    `CHK("slverr", 1'b1, e)
    finish_test();
  end
endmodule
